// *** design/ras_access_pkg.sv ***
// Package with constants and carriers for the error-record access and fault feature block.
package ras_access_pkg;

	// ----------------------------------------
	// Exception levels and trap classes
	// ----------------------------------------
	typedef enum logic [1:0] {
		LVL_USER = 2'h0,
		LVL_KERNEL = 2'h1,
		LVL_HYP = 2'h2,
		LVL_MONITOR = 2'h3
	} except_level_t;

	localparam logic [5:0] TRAP_CLASS_SYSREG = 6'h18;
	localparam int NUM_RECORDS = 4;
	localparam int SEL_W = 2;
	localparam int ADDR_W = 40;

	// ----------------------------------------
	// Feature register layout
	// ----------------------------------------
	localparam int FEAT_RESTART_BIT = 30;
	localparam int FEAT_SYN_BIT = 29;
	localparam int FEAT_MV_BIT = 12;
	localparam int FEAT_AV_BIT = 11;
	localparam int FEAT_PN_BIT = 10;
	localparam int FEAT_ER_BIT = 9;
	localparam int FEAT_CI_BIT = 8;
	localparam int FEAT_CE_LSB = 6;
	localparam int FEAT_DE_BIT = 5;
	localparam int FEAT_UC_BIT = 1;
	localparam logic [63:0] FEATURE_VALUE =
		(64'h1 << FEAT_RESTART_BIT) | (64'h1 << FEAT_CE_LSB) |
		(64'h1 << FEAT_DE_BIT) | (64'h1 << FEAT_UC_BIT);

	// ----------------------------------------
	// Request and answer carriers
	// ----------------------------------------
	typedef enum logic [1:0] {
		TGT_ADDRESS = 2'h0,
		TGT_FEATURE = 2'h1
	} sysreg_target_t;

	typedef struct packed {
		logic valid;
		logic write;
		sysreg_target_t target;
		except_level_t level;
		logic [63:0] wdata;
	} access_req_t;

	typedef struct packed {
		logic hyp_enabled;
		logic hyp_ras_trap;
		logic hyp_fault_inject_allow;
		logic hyp_fine_read_trap;
		logic hyp_fine_write_trap;
		logic fine_grain_trap_on;
		logic mon_ras_trap;
		logic mon_fault_inject_allow;
	} trap_ctrl_t;

	typedef enum logic [1:0] {
		RESP_DONE = 2'h0,
		RESP_UNDEF = 2'h1,
		RESP_TRAP_HYP = 2'h2,
		RESP_TRAP_MON = 2'h3
	} resp_kind_t;

	typedef struct packed {
		logic valid;
		resp_kind_t kind;
		logic [5:0] trap_class;
		logic [63:0] rdata;
	} access_resp_t;

	// Injected-error record event and the status updates it produces.
	typedef struct packed {
		logic valid;
		logic misc_written;
		logic addr_update;
		logic [ADDR_W-1:0] addr;
	} inject_evt_t;

endpackage

// *** design/ras_record_access.sv ***
// Trap checks for the selected record's address register and the fixed fault feature register.
//
// Summary of operation
// - Address access at user level is undefined.
// - Kernel level address access: hyp trap bit traps to hyp.
// - Kernel fine read trap bit traps reads.
// - Kernel address writes use the fine write trap.
// - Hyp, then fine, then monitor trap order.
// - Hyp level address access checks only monitor trap bit.
// - Monitor level always completes the access.
// - Feature access ignores the record select index.
// - Feature register is 64 bits, reserved zero.
// - Bit 30 reads one: restart controllable.
// - Bit 29 reads zero: fixed error codes.
// - Error codes undefined while entry unused.
// - Bit 12 zero; misc syndrome sets valid.
// - Bit 11 zero; address and valid together.
// - Bit 10 zero; injection clears poison flag.
// - Kernel feature read traps without inject allow.
// - Address bits 39:0 survive every reset.
`timescale 1ns/1ps
`default_nettype none

module ras_record_access (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire ras_access_pkg::access_req_t req_in,
	input wire ras_access_pkg::trap_ctrl_t ctrl_in,
	input wire logic [ras_access_pkg::SEL_W-1:0] record_select_in,
	input wire ras_access_pkg::inject_evt_t inject_in,
	output ras_access_pkg::access_resp_t resp_out,
	output logic [ras_access_pkg::NUM_RECORDS-1:0] address_valid_out,
	output logic [ras_access_pkg::NUM_RECORDS-1:0] misc_syndrome_valid_out,
	output logic [ras_access_pkg::NUM_RECORDS-1:0] poison_flag_out
);

	localparam int N = ras_access_pkg::NUM_RECORDS;
	localparam int AW = ras_access_pkg::ADDR_W;

	// ----------------------------------------
	// Address storage without reset
	// ----------------------------------------
	// Address contents carry no reset so that a fault logged before a reset stays readable.
	logic [AW-1:0] addr_mem [N];
	logic [AW-1:0] addr_mem_next [N];

	// ----------------------------------------
	// Reset-domain state
	// ----------------------------------------
	ras_access_pkg::access_resp_t resp_reg, resp_next;
	logic [N-1:0] av_reg, av_next;
	logic [N-1:0] mv_reg, mv_next;
	logic [N-1:0] pn_reg, pn_next;

	ras_access_pkg::resp_kind_t kind;
	logic store;
	logic want_mon;
	logic [63:0] feat;

	always_comb begin
		kind = ras_access_pkg::RESP_DONE;
		want_mon = 1'b0;
		feat = ras_access_pkg::FEATURE_VALUE;
		if (req_in.target == ras_access_pkg::TGT_ADDRESS) begin
			want_mon = ctrl_in.mon_ras_trap;
		end else begin
			want_mon = !ctrl_in.mon_fault_inject_allow;
		end
		unique case (req_in.level)
			ras_access_pkg::LVL_USER: begin
				kind = ras_access_pkg::RESP_UNDEF;
			end
			ras_access_pkg::LVL_KERNEL: begin
				if (req_in.target == ras_access_pkg::TGT_ADDRESS) begin
					if (ctrl_in.hyp_enabled && ctrl_in.hyp_ras_trap) begin
						kind = ras_access_pkg::RESP_TRAP_HYP;
					end else if (ctrl_in.hyp_enabled && ctrl_in.fine_grain_trap_on &&
						(req_in.write ? ctrl_in.hyp_fine_write_trap
						: ctrl_in.hyp_fine_read_trap)) begin
						kind = ras_access_pkg::RESP_TRAP_HYP;
					end else if (want_mon) begin
						kind = ras_access_pkg::RESP_TRAP_MON;
					end
				end else begin
					if (ctrl_in.hyp_enabled && !ctrl_in.hyp_fault_inject_allow) begin
						kind = ras_access_pkg::RESP_TRAP_HYP;
					end else if (ctrl_in.hyp_enabled && ctrl_in.fine_grain_trap_on &&
						ctrl_in.hyp_fine_read_trap) begin
						kind = ras_access_pkg::RESP_TRAP_HYP;
					end else if (want_mon) begin
						kind = ras_access_pkg::RESP_TRAP_MON;
					end
				end
			end
			ras_access_pkg::LVL_HYP: begin
				if (want_mon) begin
					kind = ras_access_pkg::RESP_TRAP_MON;
				end
			end
			ras_access_pkg::LVL_MONITOR: begin
				kind = ras_access_pkg::RESP_DONE;
			end
		endcase
		// The feature register is read-only; a write there completes with no effect.
		store = req_in.valid && req_in.write && kind == ras_access_pkg::RESP_DONE &&
			req_in.target == ras_access_pkg::TGT_ADDRESS;
	end

	always_comb begin
		resp_next = '0;
		resp_next.valid = req_in.valid;
		resp_next.kind = kind;
		if (kind == ras_access_pkg::RESP_TRAP_HYP || kind == ras_access_pkg::RESP_TRAP_MON) begin
			resp_next.trap_class = ras_access_pkg::TRAP_CLASS_SYSREG;
		end
		if (req_in.valid && !req_in.write && kind == ras_access_pkg::RESP_DONE) begin
			if (req_in.target == ras_access_pkg::TGT_ADDRESS) begin
				resp_next.rdata = {{(64 - AW){1'b0}}, addr_mem[record_select_in]};
			end else begin
				// Every record carries the same feature word; the selector is not used.
				resp_next.rdata = feat;
			end
		end
		for (int i = 0; i < N; i++) begin
			addr_mem_next[i] = addr_mem[i];
			av_next[i] = av_reg[i];
			mv_next[i] = mv_reg[i];
			pn_next[i] = pn_reg[i];
		end
		if (inject_in.valid) begin
			if (inject_in.addr_update) begin
				addr_mem_next[record_select_in] = inject_in.addr;
				av_next[record_select_in] = 1'b1;
			end
			if (inject_in.misc_written) begin
				mv_next[record_select_in] = 1'b1;
			end
			pn_next[record_select_in] = 1'b0;
		end
		// A software store after an injection in the same cycle wins the address.
		if (store) begin
			addr_mem_next[record_select_in] = req_in.wdata[AW-1:0];
		end
	end

	always_ff @(posedge clk_in) begin
		for (int i = 0; i < N; i++) begin
			addr_mem[i] <= addr_mem_next[i];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			resp_reg <= '0;
			av_reg <= '0;
			mv_reg <= '0;
			pn_reg <= '0;
		end else begin
			resp_reg <= resp_next;
			av_reg <= av_next;
			mv_reg <= mv_next;
			pn_reg <= pn_next;
		end
	end

	assign resp_out = resp_reg;
	assign address_valid_out = av_reg;
	assign misc_syndrome_valid_out = mv_reg;
	assign poison_flag_out = pn_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence user_req_s;
		req_in.valid && req_in.level == ras_access_pkg::LVL_USER;
	endsequence

	a_user_undefined: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		user_req_s |=> resp_out.valid && resp_out.kind == ras_access_pkg::RESP_UNDEF)
		else $error("user level access not undefined");

	a_hyp_trap_first: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		req_in.valid && req_in.level == ras_access_pkg::LVL_KERNEL &&
		req_in.target == ras_access_pkg::TGT_ADDRESS && ctrl_in.hyp_enabled &&
		ctrl_in.hyp_ras_trap |=> resp_out.kind == ras_access_pkg::RESP_TRAP_HYP &&
		resp_out.trap_class == 6'h18)
		else $error("hyp trap missed");

	a_fine_read_trap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		req_in.valid && !req_in.write && req_in.level == ras_access_pkg::LVL_KERNEL &&
		ctrl_in.hyp_enabled && ctrl_in.fine_grain_trap_on && ctrl_in.hyp_fine_read_trap
		|=> resp_out.kind == ras_access_pkg::RESP_TRAP_HYP)
		else $error("fine read trap missed");

	a_fine_write_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		req_in.valid && req_in.write && req_in.level == ras_access_pkg::LVL_KERNEL &&
		req_in.target == ras_access_pkg::TGT_ADDRESS && !ctrl_in.hyp_ras_trap &&
		ctrl_in.hyp_enabled && ctrl_in.fine_grain_trap_on && !ctrl_in.hyp_fine_write_trap &&
		!ctrl_in.mon_ras_trap |=> resp_out.kind == ras_access_pkg::RESP_DONE)
		else $error("write used read trap bit");

	a_mon_trap_hyp: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		req_in.valid && req_in.level == ras_access_pkg::LVL_HYP &&
		req_in.target == ras_access_pkg::TGT_ADDRESS
		|=> resp_out.kind == ($past(ctrl_in.mon_ras_trap) ?
		ras_access_pkg::RESP_TRAP_MON : ras_access_pkg::RESP_DONE))
		else $error("hyp level monitor check wrong");

	a_monitor_done: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		req_in.valid && req_in.level == ras_access_pkg::LVL_MONITOR
		|=> resp_out.kind == ras_access_pkg::RESP_DONE)
		else $error("monitor access trapped");

	a_feature_value: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		req_in.valid && !req_in.write && req_in.target == ras_access_pkg::TGT_FEATURE &&
		req_in.level == ras_access_pkg::LVL_MONITOR
		|=> resp_out.rdata[30] && !resp_out.rdata[29] && resp_out.rdata[63:31] == '0 &&
		resp_out.rdata[12:10] == 3'h0)
		else $error("feature word wrong");

	a_write_readback: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		req_in.valid && req_in.write && req_in.level == ras_access_pkg::LVL_MONITOR &&
		req_in.target == ras_access_pkg::TGT_ADDRESS ##1
		req_in.valid && !req_in.write && req_in.level == ras_access_pkg::LVL_MONITOR &&
		req_in.target == ras_access_pkg::TGT_ADDRESS &&
		record_select_in == $past(record_select_in) && !$past(inject_in.valid)
		|=> resp_out.rdata[39:0] == $past(req_in.wdata[39:0], 2))
		else $error("address readback wrong");

	a_poison_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		inject_in.valid |=> !poison_flag_out[$past(record_select_in)])
		else $error("poison flag not cleared");

endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the record access and fault feature block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	ras_access_pkg::access_req_t req_in = '0;
	ras_access_pkg::trap_ctrl_t ctrl_in = '0;
	logic [1:0] record_select_in = 2'h0;
	ras_access_pkg::inject_evt_t inject_in = '0;
	ras_access_pkg::access_resp_t resp_out;
	logic [3:0] address_valid_out;
	logic [3:0] misc_syndrome_valid_out;
	logic [3:0] poison_flag_out;
	int fail_count = 0;
	int check_count = 0;
	localparam logic [63:0] FEAT = 64'h0000_0000_4000_0062;
	localparam logic [63:0] A = 64'hFFFF_FF12_3456_789A;
	localparam logic [63:0] A_RD = 64'h0000_0012_3456_789A;

	always #5 clk_in = ~clk_in;

	ras_record_access dut (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.req_in(req_in),
		.ctrl_in(ctrl_in),
		.record_select_in(record_select_in),
		.inject_in(inject_in),
		.resp_out(resp_out),
		.address_valid_out(address_valid_out),
		.misc_syndrome_valid_out(misc_syndrome_valid_out),
		.poison_flag_out(poison_flag_out)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One access: driven at a falling edge and taken at the next rising edge.
	// The answer is checked at the following falling edge, while it stands.
	task automatic ex(input logic wr, input logic [1:0] tgt, input logic [1:0] lvl,
			input logic [63:0] wd, input logic [1:0] kind, input logic [63:0] rd);
		@(negedge clk_in);
		req_in = {1'b1, wr, tgt, lvl, wd};
		@(negedge clk_in);
		req_in = '0;
		chk("resp", {55'h0, 1'b1, kind, kind[1] ? 6'h18 : 6'h00},
			{55'h0, resp_out.valid, resp_out.kind, resp_out.trap_class});
		chk("rdata", rd, resp_out.rdata);
	endtask

	task automatic inj(input logic misc, input logic upd, input logic [39:0] addr);
		@(negedge clk_in);
		inject_in = {1'b1, misc, upd, addr};
		@(negedge clk_in);
		inject_in = '0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_levels;
		record_select_in = 2'h1;
		ex(1'b1, 2'h0, 2'h3, A, 2'h0, 64'h0);
		ex(1'b0, 2'h0, 2'h3, 64'h0, 2'h0, A_RD);
		ex(1'b0, 2'h0, 2'h0, 64'h0, 2'h1, 64'h0);
		ex(1'b1, 2'h0, 2'h0, 64'h11, 2'h1, 64'h0);
		ctrl_in = 8'hC2;
		ex(1'b0, 2'h0, 2'h2, 64'h0, 2'h3, 64'h0);
		ex(1'b1, 2'h0, 2'h2, 64'h22, 2'h3, 64'h0);
		ex(1'b1, 2'h0, 2'h3, 64'h33, 2'h0, 64'h0);
		ctrl_in = 8'hC0;
		ex(1'b0, 2'h0, 2'h2, 64'h0, 2'h0, 64'h33);
		$display("test levels done");
	endtask

	// Trapped writes must leave the stored address alone.
	task automatic t_kernel;
		ctrl_in = '0;
		record_select_in = 2'h2;
		ex(1'b1, 2'h0, 2'h3, A, 2'h0, 64'h0);
		ctrl_in = 8'hD6;
		ex(1'b0, 2'h0, 2'h1, 64'h0, 2'h2, 64'h0);
		ex(1'b1, 2'h0, 2'h1, 64'h44, 2'h2, 64'h0);
		ctrl_in.hyp_ras_trap = 1'b0;
		ex(1'b0, 2'h0, 2'h1, 64'h0, 2'h2, 64'h0);
		ex(1'b1, 2'h0, 2'h1, 64'h44, 2'h3, 64'h0);
		ctrl_in.hyp_fine_write_trap = 1'b1;
		ex(1'b1, 2'h0, 2'h1, 64'h44, 2'h2, 64'h0);
		ctrl_in.fine_grain_trap_on = 1'b0;
		ex(1'b0, 2'h0, 2'h1, 64'h0, 2'h3, 64'h0);
		ctrl_in = 8'h40;
		ex(1'b0, 2'h0, 2'h1, 64'h0, 2'h0, A_RD);
		ctrl_in = '0;
		ex(1'b1, 2'h0, 2'h1, 64'h55, 2'h0, 64'h0);
		ex(1'b0, 2'h0, 2'h1, 64'h0, 2'h0, 64'h55);
		ctrl_in = 8'h94;
		ex(1'b1, 2'h0, 2'h1, 64'h66, 2'h0, 64'h0);
		ex(1'b0, 2'h0, 2'h1, 64'h0, 2'h2, 64'h0);
		ex(1'b0, 2'h0, 2'h3, 64'h0, 2'h0, 64'h66);
		// Back-to-back write and read of the same record.
		@(negedge clk_in);
		req_in = {1'b1, 1'b1, 2'h0, 2'h3, 64'h99};
		@(negedge clk_in);
		req_in = {1'b1, 1'b0, 2'h0, 2'h3, 64'h0};
		chk("b2b write resp", 64'h4, {61'h0, resp_out.valid, resp_out.kind});
		@(negedge clk_in);
		req_in = '0;
		chk("b2b rdata", 64'h99, resp_out.rdata);
		ctrl_in = '0;
		$display("test kernel done");
	endtask

	task automatic t_feature;
		for (int s = 0; s < 4; s++) begin
			record_select_in = s[1:0];
			ex(1'b0, 2'h1, 2'h3, 64'h0, 2'h0, FEAT);
		end
		ex(1'b1, 2'h1, 2'h3, 64'hFFFF_FFFF_FFFF_FFFF, 2'h0, 64'h0);
		ex(1'b0, 2'h1, 2'h3, 64'h0, 2'h0, FEAT);
		ctrl_in = 8'h81;
		ex(1'b0, 2'h1, 2'h1, 64'h0, 2'h2, 64'h0);
		ctrl_in = 8'hA1;
		ex(1'b0, 2'h1, 2'h1, 64'h0, 2'h0, FEAT);
		ctrl_in = 8'hB5;
		ex(1'b0, 2'h1, 2'h1, 64'h0, 2'h2, 64'h0);
		ctrl_in = 8'hA0;
		ex(1'b0, 2'h1, 2'h1, 64'h0, 2'h3, 64'h0);
		ex(1'b0, 2'h1, 2'h2, 64'h0, 2'h3, 64'h0);
		$display("test feature done");
	endtask

	// Address storage has no reset, so it must outlive a reset in mid-run.
	task automatic t_inject;
		ctrl_in = '0;
		record_select_in = 2'h3;
		ex(1'b1, 2'h0, 2'h3, 64'h77, 2'h0, 64'h0);
		inj(1'b1, 1'b1, 40'hAB_CDEF_0011);
		chk("address_valid", 64'h8, {60'h0, address_valid_out});
		chk("misc_valid", 64'h8, {60'h0, misc_syndrome_valid_out});
		chk("poison", 64'h0, {60'h0, poison_flag_out});
		ex(1'b0, 2'h0, 2'h3, 64'h0, 2'h0, 64'h0000_00AB_CDEF_0011);
		inj(1'b0, 1'b0, 40'h55_5555_5555);
		chk("poison", 64'h0, {60'h0, poison_flag_out});
		ex(1'b0, 2'h0, 2'h3, 64'h0, 2'h0, 64'h0000_00AB_CDEF_0011);
		rst_b_in = 1'b0;
		repeat (2) @(negedge clk_in);
		chk("status in reset", 64'h0, {52'h0, address_valid_out, poison_flag_out,
			misc_syndrome_valid_out});
		rst_b_in = 1'b1;
		ex(1'b0, 2'h0, 2'h3, 64'h0, 2'h0, 64'h0000_00AB_CDEF_0011);
		$display("test inject done");
	endtask

	initial begin
		#200000;
		fail_count++;
		close_out();
	end

	initial begin
		repeat (12) @(negedge clk_in);
		rst_b_in = 1'b1;
		t_levels();
		t_kernel();
		t_feature();
		t_inject();
		close_out();
	end
endmodule

`default_nettype wire
